// [logic/spims_core.sv]
// Purpose: spi master/slave core with normal and buffered operation
// Assumes: single clock; pin inputs asynchronous; software drives control ports
// Notes: all state kept in one struct, registered in a single process
`timescale 1ns/1ps
`default_nettype none
module spims_core
  import spims_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // configuration
  input wire logic i_enable,
  input wire logic i_master_set,         // pulse: software sets master bit
  input wire logic i_select_pin_disable,
  input wire logic i_select_pin_is_output,
  input wire logic i_miso_is_output,
  input wire logic i_buffered_mode_enable,
  input wire logic i_wait_for_receive_select,
  input wire logic i_transfer_done_irq_enable,
  input wire logic i_all_sent_irq_enable,
  input wire logic i_rx_complete_irq_enable,
  input wire logic i_tx_empty_irq_enable,
  // data access
  input wire logic i_data_write,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_data_read,
  input wire logic [3:0] i_flag_clear,   // pulses: done, collision, all sent, rx
  // pins
  input wire logic i_select_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_mosi,
  output logic o_mosi_oe,
  output logic o_miso,
  output logic o_miso_oe,
  // status
  output logic o_master,
  output logic [7:0] o_data_rdata,
  output logic o_transfer_done_flag,
  output logic o_write_collision_flag,
  output logic o_tx_buffer_empty_flag,
  output logic o_receive_complete_flag,
  output logic o_all_sent_flag,
  output logic o_irq
);

  // whole state of the core
  typedef struct packed {
    logic [1:0] ss_sync;      // select synchroniser
    logic [1:0] sck_sync;     // sck synchroniser
    logic [1:0] mosi_sync;    // mosi synchroniser
    logic [1:0] miso_sync;    // miso synchroniser, selected only after both stages
    logic ss_prev;            // last synced select
    logic sck_prev;           // last synced sck
    logic master;             // master bit
    spims_state_type state;   // transfer state
    logic [3:0] div;          // sck half-period count
    logic [3:0] bits;         // bits shifted
    logic [7:0] shift;        // shift register
    logic in_bit;             // sampled input bit
    logic [7:0] tx_buf;       // transmit buffer
    logic tx_full;            // tx buffer holds data
    logic [7:0] rx0;          // first receive buffer
    logic [7:0] rx1;          // second receive buffer
    logic [1:0] rx_count;     // fifo fill
    logic done_f;             // transfer done flag
    logic wcol_f;             // write collision flag
    logic rxc_f;              // receive complete flag
    logic txc_f;              // all sent flag
    logic rxc_pend;           // delays rx flag one cycle
    logic txc_pend;           // delays all sent flag one more
    logic preload;            // slave buffered: move buffer next cycle
    logic sck_out;            // master sck drive
    logic miso_oe;            // registered miso enable
    logic irq;                // registered request
  } spims_regs_type;

  spims_regs_type r_reg;
  spims_regs_type r_next;

  // buffered-mode empty flag is derived from buffer fill
  function automatic logic spims_tx_empty(input spims_regs_type s);
    spims_tx_empty = !s.tx_full;
  endfunction

  // next-state logic
  always_comb begin
    logic ss_n;
    logic sck_s;
    logic sck_rise;
    logic sck_fall;
    logic busy;
    logic byte_end;
    logic sel_low;
    logic [7:0] rx_byte;
    ss_n = 1'b1;
    sck_s = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    busy = 1'b0;
    byte_end = 1'b0;
    sel_low = 1'b0;
    rx_byte = SPIMS_DATA_RST;
    r_next = r_reg;
    // synchronisers: first stage feeds only the second
    r_next.ss_sync = {r_reg.ss_sync[0], i_select_n};
    r_next.sck_sync = {r_reg.sck_sync[0], i_sck};
    r_next.mosi_sync = {r_reg.mosi_sync[0], i_mosi}; // slave data in
    r_next.miso_sync = {r_reg.miso_sync[0], i_miso}; // master data in
    ss_n = r_reg.ss_sync[1];
    sck_s = r_reg.sck_sync[1];
    r_next.ss_prev = ss_n;
    r_next.sck_prev = sck_s;
    sck_rise = sck_s && !r_reg.sck_prev;
    sck_fall = !sck_s && r_reg.sck_prev;
    busy = (r_reg.state != SPIMS_IDLE);
    // software clears, applied before hardware sets so sets win
    if (i_flag_clear[0]) r_next.done_f = 1'b0;
    if (i_flag_clear[1]) r_next.wcol_f = 1'b0;
    if (i_flag_clear[2]) r_next.txc_f = 1'b0;
    if (i_flag_clear[3]) r_next.rxc_f = 1'b0;
    if (i_master_set) r_next.master = 1'b1;
    // delayed flag pipeline for buffered mode
    r_next.rxc_pend = 1'b0;
    r_next.txc_pend = 1'b0;
    if (r_reg.rxc_pend) begin
      r_next.rxc_f = 1'b1;
      r_next.txc_pend = !r_reg.tx_full;
    end
    if (r_reg.txc_pend && !r_reg.tx_full && !busy) begin
      r_next.txc_f = 1'b1;
    end
    // reading pops the fifo in buffered mode
    if (i_data_read && i_buffered_mode_enable && r_reg.rx_count != 2'h0) begin
      r_next.rx0 = r_reg.rx1;
      r_next.rx_count = r_reg.rx_count - 2'h1;
      if (r_reg.rx_count == 2'h1) r_next.rxc_f = 1'b0;
    end
    // data writes
    if (i_data_write && i_enable) begin
      if (i_buffered_mode_enable) begin
        if (!r_reg.tx_full) begin
          if (r_reg.master && !busy) begin
            r_next.shift = i_data_wdata; // first write sent at once
            r_next.state = SPIMS_LOW;
            r_next.div = 4'h0;
            r_next.bits = 4'h0;
          end else begin
            r_next.tx_buf = i_data_wdata;
            r_next.tx_full = 1'b1;
            r_next.txc_f = 1'b0;
            // deselected slave pulls buffer in next cycle when not waiting
            r_next.preload = !r_reg.master && ss_n && !i_wait_for_receive_select;
          end
        end
        // write while buffer full is lost, as the flag already warns
      end else if (busy) begin
        r_next.wcol_f = 1'b1; // shift register left unchanged
      end else begin
        r_next.shift = i_data_wdata; // buffer unused
        if (r_reg.master) begin
          r_next.state = SPIMS_LOW;
          r_next.div = 4'h0;
          r_next.bits = 4'h0;
        end
      end
    end
    if (r_reg.preload && r_reg.tx_full && !busy) begin
      r_next.shift = r_reg.tx_buf;
      r_next.tx_full = 1'b0;
      r_next.preload = 1'b0;
    end
    // multi-master fallback
    sel_low = !ss_n;
    if (r_reg.master && i_enable && !i_select_pin_disable && !i_select_pin_is_output
        && sel_low) begin
      r_next.master = 1'b0;
      r_next.done_f = 1'b1;
      r_next.state = SPIMS_IDLE;
      r_next.sck_out = 1'b0;
    end else if (r_reg.master && i_enable) begin
      // master shifter: mode 0, msb first
      r_next.div = r_reg.div + 4'h1;
      case (r_reg.state)
        SPIMS_IDLE: begin
          r_next.div = 4'h0;
        end
        SPIMS_LOW: begin
          if (r_reg.div == SPIMS_HALF_DIV - 4'h1) begin
            r_next.div = 4'h0;
            r_next.sck_out = 1'b1;
            r_next.in_bit = r_reg.miso_sync[1];
            r_next.state = SPIMS_HIGH;
          end
        end
        SPIMS_HIGH: begin
          if (r_reg.div == SPIMS_HALF_DIV - 4'h1) begin
            r_next.div = 4'h0;
            r_next.sck_out = 1'b0;
            r_next.shift = {r_reg.shift[6:0], r_reg.in_bit};
            r_next.bits = r_reg.bits + 4'h1;
            r_next.state = (r_reg.bits + 4'h1 == SPIMS_BIT_LAST) ? SPIMS_DONE : SPIMS_LOW;
          end
        end
        SPIMS_DONE: begin
          byte_end = 1'b1; // eight bits out
          r_next.state = SPIMS_IDLE;
        end
        default: begin
          r_next.state = SPIMS_IDLE;
        end
      endcase
    end else if (!r_reg.master && i_enable) begin
      // slave shifter, clocked by synced sck edges
      r_next.sck_out = 1'b0;
      if (ss_n) begin
        if (!r_reg.ss_prev) begin
          r_next.bits = 4'h0; // rising select resets, partial byte dropped
        end
        r_next.state = SPIMS_IDLE;
      end else begin
        case (r_reg.state)
          SPIMS_IDLE: begin
            r_next.bits = 4'h0;
            if (sck_rise) begin
              r_next.in_bit = r_reg.mosi_sync[1];
              r_next.state = SPIMS_HIGH;
            end
          end
          SPIMS_LOW: begin
            if (sck_rise) begin
              r_next.in_bit = r_reg.mosi_sync[1];
              r_next.state = SPIMS_HIGH;
            end
          end
          SPIMS_HIGH: begin
            if (sck_fall) begin
              r_next.shift = {r_reg.shift[6:0], r_reg.in_bit};
              r_next.bits = r_reg.bits + 4'h1;
              r_next.state = (r_reg.bits + 4'h1 == SPIMS_BIT_LAST) ? SPIMS_DONE : SPIMS_LOW;
            end
          end
          SPIMS_DONE: begin
            byte_end = 1'b1;
            r_next.state = SPIMS_IDLE;
          end
          default: begin
            r_next.state = SPIMS_IDLE;
          end
        endcase
      end
    end else begin
      r_next.state = SPIMS_IDLE;
      r_next.sck_out = 1'b0;
    end
    // end of byte: store received data; buffered mode reloads a held byte
    if (byte_end) begin
      rx_byte = r_reg.shift;
      if (i_buffered_mode_enable) begin
        if (r_reg.rx_count == 2'h0) begin
          r_next.rx0 = rx_byte;
          r_next.rx_count = 2'h1;
        end else begin
          r_next.rx1 = rx_byte; // third unread byte overwrites newest
          r_next.rx_count = 2'h2;
        end
        r_next.rxc_pend = 1'b1;
        if (r_reg.tx_full) begin
          r_next.shift = r_reg.tx_buf;
          r_next.tx_full = 1'b0;
          if (r_reg.master) begin
            r_next.state = SPIMS_LOW; // held byte follows
            r_next.div = 4'h0;
            r_next.bits = 4'h0;
          end
        end
      end else begin
        r_next.rx0 = rx_byte; // unread byte overwritten
        r_next.done_f = 1'b1;
      end
    end
    // miso drive only in selected slave with output direction
    // next master bit used so miso never drives in the cycle master is set
    r_next.miso_oe = !r_next.master && i_enable && !ss_n && i_miso_is_output;
    // one request line from enabled flags
    r_next.irq = (r_next.done_f && i_transfer_done_irq_enable)
      || (r_next.txc_f && i_all_sent_irq_enable)
      || (r_next.rxc_f && i_rx_complete_irq_enable)
      || (!r_next.tx_full && i_buffered_mode_enable && i_tx_empty_irq_enable);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
      r_reg.ss_sync <= SPIMS_SYNC_RST;
      r_reg.ss_prev <= 1'b1;
      r_reg.state <= SPIMS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign o_sck = r_reg.sck_out;
  assign o_sck_oe = r_reg.master;
  assign o_mosi = r_reg.shift[7];
  assign o_mosi_oe = r_reg.master;
  assign o_miso = r_reg.shift[7];
  assign o_miso_oe = r_reg.miso_oe;
  assign o_master = r_reg.master;
  assign o_data_rdata = r_reg.rx0;
  assign o_transfer_done_flag = r_reg.done_f;
  assign o_write_collision_flag = r_reg.wcol_f;
  assign o_tx_buffer_empty_flag = spims_tx_empty(r_reg);
  assign o_receive_complete_flag = r_reg.rxc_f;
  assign o_all_sent_flag = r_reg.txc_f;
  assign o_irq = r_reg.irq;

endmodule
`default_nettype wire

// [logic/spims_pkg.sv]
// Purpose: constants shared by the byte-wide spi master/slave core
// Assumes: 200 MHz peripheral clock
// Notes: sck divider fixed; data mode 0, msb first
package spims_pkg;
  localparam int unsigned SPIMS_BITS = 8;           // bits per transfer
  localparam logic [3:0] SPIMS_BIT_LAST = 4'h8;     // bit count at byte end
  localparam logic [3:0] SPIMS_HALF_DIV = 4'h4;     // clocks per sck half period
  localparam logic [7:0] SPIMS_DATA_RST = 8'h00;    // shift and buffer reset value
  localparam logic [1:0] SPIMS_SYNC_RST = 2'h3;     // synchroniser idle (pins high)
  typedef enum logic [1:0] {
    SPIMS_IDLE = 2'b00,
    SPIMS_LOW = 2'b01,
    SPIMS_HIGH = 2'b10,
    SPIMS_DONE = 2'b11
  } spims_state_type;
endpackage

// [test/spims_core_assertions.sv]
// Purpose: port-level checks on the spi core
// Assumes: one clock, async active-low reset
// Notes: bound to every core instance
`timescale 1ns/1ps
`default_nettype none
module spims_core_assertions (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // controls
  input wire logic i_enable,
  input wire logic i_select_pin_disable,
  input wire logic i_select_pin_is_output,
  input wire logic i_miso_is_output,
  input wire logic i_buffered_mode_enable,
  input wire logic i_transfer_done_irq_enable,
  input wire logic i_data_write,
  input wire logic [3:0] i_flag_clear,
  input wire logic i_select_n,
  // outputs watched
  input wire logic o_sck_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe,
  input wire logic o_master,
  input wire logic o_transfer_done_flag,
  input wire logic o_write_collision_flag,
  input wire logic o_receive_complete_flag,
  input wire logic o_all_sent_flag,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  AST_DONE_STICKY: assert property (
    o_transfer_done_flag && !i_flag_clear[0] |=> o_transfer_done_flag)
    else $error("done flag fell without clear");
  AST_SEL_DIS_KEEP: assert property (
    o_master && i_select_pin_disable && i_enable |=> o_master)
    else $error("master lost with select disabled");
  AST_SSOUT_KEEP: assert property (
    o_master && i_select_pin_is_output && i_enable |=> o_master)
    else $error("master lost with select as output");
  // synchroniser delay allowed before the drop
  AST_DROP: assert property (
    (o_master && !i_select_n && !i_select_pin_disable
    && !i_select_pin_is_output && i_enable) [*3] |-> ##[0:3] !o_master)
    else $error("master kept with select low");
  AST_DROP_FLAG: assert property (
    $fell(o_master) |-> ##[0:1] o_transfer_done_flag)
    else $error("drop without done flag");
  AST_COLL: assert property (
    $rose(o_write_collision_flag) |-> $past(i_data_write) || $past(i_data_write, 2))
    else $error("collision without write");
  AST_ALL_SENT: assert property (
    $rose(o_all_sent_flag) && i_buffered_mode_enable |-> $past(o_receive_complete_flag))
    else $error("all sent before rx flag");
  AST_IRQ_ON: assert property (
    $past(i_transfer_done_irq_enable && o_transfer_done_flag && !i_flag_clear[0]) |-> o_irq)
    else $error("enabled flag without irq");
  AST_SLAVE_PINS: assert property (
    !o_master [*2] |-> !o_sck_oe && !o_mosi_oe)
    else $error("slave drives sck or mosi");
  AST_MISO_OE: assert property (
    o_miso_oe |-> !o_master && $past(i_miso_is_output))
    else $error("miso driven wrongly");
  // main scenarios reached
  cover property ($rose(o_transfer_done_flag) && o_master);
  cover property ($rose(o_all_sent_flag));
  cover property ($fell(o_master));
endmodule
bind spims_core spims_core_assertions spims_core_assertions_i (.i_clk, .i_nrst, .i_enable,
  .i_select_pin_disable, .i_select_pin_is_output, .i_miso_is_output, .i_buffered_mode_enable,
  .i_transfer_done_irq_enable, .i_data_write, .i_flag_clear, .i_select_n, .o_sck_oe,
  .o_mosi_oe, .o_miso_oe, .o_master, .o_transfer_done_flag, .o_write_collision_flag,
  .o_receive_complete_flag, .o_all_sent_flag, .o_irq);
`default_nettype wire

// [test/spims_far_slave.sv]
// Purpose: far-side spi slave for the core in master mode
// Assumes: mode 0, msb first, byte reloaded from i_tx
// Notes: behavioural; released miso shows inverse of last bit
`timescale 1ns/1ps
`default_nettype none
module spims_far_slave (
  // bus pins
  input wire logic i_sel_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  // byte to return and byte taken
  input wire logic [7:0] i_tx,
  output logic [7:0] o_rx
);
  logic [7:0] sh; // shift register
  logic [2:0] cnt; // bits seen this byte
  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
  end
  // load on select so msb stands before the first rising edge
  always @(negedge i_sel_n) begin
    sh = i_tx;
    o_miso = i_tx[7];
    cnt = 3'h0;
  end
  // sample on rising, reload after eight bits for back-to-back bytes
  always @(posedge i_sck) if (!i_sel_n) begin
    sh = {sh[6:0], i_mosi};
    cnt++;
    if (cnt == 3'h0) begin
      o_rx = sh;
      sh = i_tx;
    end
  end
  // shift out on falling
  always @(negedge i_sck) if (!i_sel_n) o_miso = sh[7];
  // released line: no pull, so never keep the last level
  always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule
`default_nettype wire

// [test/testbench.sv]
// Purpose: self-checking bench for the spi master/slave core
// Assumes: 200 MHz clock; partner slave on the master side
// Notes: bench plays the external master in slave tests
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spims_pkg::*;
  // design inputs
  logic i_clk = 0, i_nrst = 0, i_master_set = 0, i_select_pin_disable = 0;
  logic i_select_pin_is_output = 1, i_buffered_mode_enable = 0, i_wait_for_receive_select = 0;
  logic i_miso_is_output = 1, i_tx_empty_irq_enable = 0;
  logic i_transfer_done_irq_enable = 0, i_all_sent_irq_enable = 0, i_rx_complete_irq_enable = 0;
  logic i_data_write = 0, i_data_read = 0, i_select_n = 1, e_sck = 0, e_mosi = 0, p_sel_n = 1;
  logic [7:0] i_data_wdata = 0, p_tx = 0, p_rx, dv, mv, b2, got;
  logic [3:0] i_flag_clear = 0;
  // design outputs
  logic o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_master, o_irq, p_miso;
  logic o_transfer_done_flag, o_write_collision_flag, o_tx_buffer_empty_flag;
  logic o_receive_complete_flag, o_all_sent_flag;
  logic [7:0] o_data_rdata;
  int errors = 0, checks_done = 0;
  // pin levels: whoever enables drives the wire
  wire logic i_sck = o_sck_oe ? o_sck : e_sck;
  wire logic i_mosi = o_mosi_oe ? o_mosi : e_mosi;
  wire logic i_miso = o_miso_oe ? o_miso : p_miso;
  spims_core spims_core_i (.i_clk, .i_nrst, .i_enable(1'b1), .i_master_set, .i_select_pin_disable,
    .i_select_pin_is_output, .i_miso_is_output, .i_buffered_mode_enable,
    .i_wait_for_receive_select, .i_transfer_done_irq_enable, .i_all_sent_irq_enable,
    .i_rx_complete_irq_enable, .i_tx_empty_irq_enable, .i_data_write, .i_data_wdata,
    .i_data_read, .i_flag_clear, .i_select_n, .i_sck, .i_mosi, .i_miso, .o_sck, .o_sck_oe,
    .o_mosi, .o_mosi_oe, .o_miso, .o_miso_oe, .o_master, .o_data_rdata, .o_transfer_done_flag,
    .o_write_collision_flag, .o_tx_buffer_empty_flag, .o_receive_complete_flag,
    .o_all_sent_flag, .o_irq);
  spims_far_slave spims_far_slave_i (.i_sel_n(p_sel_n), .i_sck, .i_mosi, .o_miso(p_miso),
    .i_tx(p_tx), .o_rx(p_rx));
  initial forever #2.5 i_clk = ~i_clk;
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one-cycle pulses of write, read, master set and clears
  task automatic go(input logic w, r, s, input logic [3:0] c, input logic [7:0] v);
    @(posedge i_clk);
    {i_data_write, i_data_read, i_master_set, i_flag_clear, i_data_wdata} <= {w, r, s, c, v};
    @(posedge i_clk);
    {i_data_write, i_data_read, i_master_set, i_flag_clear} <= 7'h00;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait: k=0 done flag, k=1 all sent
  task automatic waitf(input int k);
    int n = 0;
    while (!(k ? o_all_sent_flag : o_transfer_done_flag) && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      test_done();
    end
  endtask
  // external master: 4-clock sck high half, 5 or 6 low, early write at bit 4 if cw
  task automatic ext(input logic [7:0] v, input int stop, input bit cw);
    for (int i = 0; i < stop; i++) begin
      e_mosi <= v[7-i];
      wt(4);
      #1 got[7-i] = i_miso;
      // sck rises on a clock edge; the low half stretches by a cycle or two
      if (i == 4 && cw) go(1, 0, 0, 4'h0, 8'h3C);
      else wt(1);
      e_sck <= 1;
      wt(4);
      e_sck <= 0;
    end
  endtask
  task automatic mx(input logic [7:0] v, input logic [7:0] pv);
    p_sel_n <= 1;
    p_tx <= pv;
    wt(1);
    p_sel_n <= 0;
    chk({7'h0, o_master}, 8'h01);
    go(1, 0, 0, 4'h0, v);
    waitf(0);
    wt(2);
    chk(p_rx, v);
    chk(o_data_rdata, pv);
  endtask
  initial begin
    void'($urandom(60117));
    wt(12);
    i_nrst <= 1;
    wt(1);
    chk({4'h0, o_master, o_transfer_done_flag, o_tx_buffer_empty_flag, o_irq}, 8'h02);
    // slave: load while deselected, early write mid-byte
    dv = 8'($urandom);
    mv = 8'($urandom);
    go(1, 0, 0, 4'h0, dv);
    i_select_n <= 0;
    wt(6);
    chk({7'h0, o_miso_oe}, 8'h01);
    ext(mv, 8, 1);
    waitf(0);
    chk(got, dv);
    chk(o_data_rdata, mv);
    chk({7'h0, o_write_collision_flag}, 8'h01);
    i_select_n <= 1;
    wt(6);
    chk({7'h0, o_miso_oe}, 8'h00);
    // deselect mid-byte, then a clean byte
    go(0, 0, 0, 4'hF, 8'h00);
    go(1, 0, 0, 4'h0, ~dv);
    i_miso_is_output <= 0;
    i_select_n <= 0;
    wt(6);
    chk({7'h0, o_miso_oe}, 8'h00);
    ext(mv, 3, 0);
    i_select_n <= 1;
    i_miso_is_output <= 1;
    wt(10);
    chk({7'h0, o_transfer_done_flag}, 8'h00);
    go(1, 0, 0, 4'h0, dv ^ 8'h5A);
    i_select_n <= 0;
    wt(6);
    ext(~mv, 8, 0);
    waitf(0);
    chk(got, dv ^ 8'h5A);
    chk(o_data_rdata, ~mv);
    $display("slave tests done");
    // master normal, select pin as plain output held low
    go(0, 0, 1, 4'hF, 8'h00);
    i_select_n <= 0;
    i_transfer_done_irq_enable <= 1;
    i_wait_for_receive_select <= 1'($urandom);
    for (int k = 0; k < 4; k++) begin
      mx(k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($urandom), 8'($urandom));
      chk({7'h0, o_irq}, 8'h01);
      go(0, 0, 0, 4'h1, 8'h00);
      wt(2);
      chk({7'h0, o_irq}, 8'h00);
    end
    go(1, 0, 0, 4'h0, 8'hA5);
    wt(10);
    go(1, 0, 0, 4'h0, 8'h5A);
    waitf(0);
    chk({7'h0, o_write_collision_flag}, 8'h01);
    i_select_pin_disable <= 1;
    i_select_pin_is_output <= 0;
    go(0, 0, 0, 4'hF, 8'h00);
    mx(8'($urandom), 8'h96);
    chk({7'h0, o_master}, 8'h01);
    $display("master normal tests done");
    // buffered: second write held, fifo read in order
    i_buffered_mode_enable <= 1;
    i_all_sent_irq_enable <= 1;
    dv = 8'($urandom);
    mv = 8'($urandom);
    b2 = 8'($urandom);
    go(0, 0, 0, 4'hF, 8'h00);
    p_sel_n <= 1;
    p_tx <= dv;
    wt(1);
    p_sel_n <= 0;
    go(1, 0, 0, 4'h0, 8'h81);
    go(1, 0, 0, 4'h0, b2);
    p_tx <= mv;
    wt(1);
    chk({7'h0, o_tx_buffer_empty_flag}, 8'h00);
    waitf(1);
    wt(2);
    chk(p_rx, b2);
    chk({6'h0, o_receive_complete_flag, o_irq}, 8'h03);
    chk({7'h0, o_tx_buffer_empty_flag}, 8'h01);
    chk(o_data_rdata, dv);
    go(0, 1, 0, 4'h0, 8'h00);
    wt(1);
    chk(o_data_rdata, mv);
    // empty flag alone raises the request once its enable is set
    i_all_sent_irq_enable <= 0;
    wt(2);
    chk({7'h0, o_irq}, 8'h00);
    i_tx_empty_irq_enable <= 1;
    wt(2);
    chk({7'h0, o_irq}, 8'h01);
    i_tx_empty_irq_enable <= 0;
    $display("buffered tests done");
    // select input low takes the master bit away
    i_buffered_mode_enable <= 0;
    i_select_pin_disable <= 0;
    wt(8);
    chk({6'h0, o_master, o_transfer_done_flag}, 8'h01);
    i_select_n <= 1;
    wt(4);
    go(0, 0, 1, 4'hF, 8'h00);
    wt(2);
    chk({7'h0, o_master}, 8'h01);
    i_nrst <= 0;
    wt(2);
    chk({7'h0, o_master}, 8'h00);
    i_nrst <= 1;
    wt(2);
    $display("drop and reset tests done");
    test_done();
  end
endmodule
`default_nettype wire
